// ---- hdl/aer_pkg.sv ----
// Purpose: Shared constants and carriers for the error report registers
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes:   Offsets are byte addresses
package aer_pkg;

    localparam logic [11:0] OFS_SEV    = 12'h10C;
    localparam logic [11:0] OFS_CSTS   = 12'h110;
    localparam logic [11:0] OFS_CMSK   = 12'h114;
    localparam logic [11:0] OFS_CAP    = 12'h118;
    localparam logic [11:0] OFS_HDR0   = 12'h11C;
    localparam logic [11:0] OFS_HDR1   = 12'h120;
    localparam logic [11:0] OFS_HDR2   = 12'h124;
    localparam logic [11:0] OFS_HDR3   = 12'h128;

    // Implemented bits and reset values
    localparam logic [31:0] SEV_BITS   = 32'h003FF011;
    localparam logic [31:0] SEV_RST    = 32'h00062011;
    localparam logic [31:0] COR_BITS   = 32'h000031C1;
    localparam logic [31:0] CMSK_RST   = 32'h00002000;
    localparam logic [31:0] CSTS_RST   = 32'h00000000;

    // Correctable event bit positions
    localparam int COR_RX_ERR          = 0;
    localparam int COR_BAD_TLP         = 6;
    localparam int COR_BAD_DLLP        = 7;
    localparam int COR_REPLAY_ROLL     = 8;
    localparam int COR_REPLAY_TMO      = 12;
    localparam int COR_ADV_NF          = 13;

    // Capability and control fields
    localparam int CAP_FEP_LSB         = 0;
    localparam int CAP_GEN_CAP         = 5;
    localparam int CAP_GEN_EN          = 6;
    localparam int CAP_CHK_CAP         = 7;
    localparam int CAP_CHK_EN          = 8;
    localparam logic [4:0]  FEP_RST    = 5'h00;

    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;

    typedef struct packed {
        logic        awvalid;
        logic [11:0] awaddr;
        logic        wvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        bready;
        logic        arvalid;
        logic [11:0] araddr;
        logic        rready;
    } aer_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } aer_axi_rsp_t;

    // Correctable events, one-cycle pulses
    typedef struct packed {
        logic rx_err;
        logic bad_tlp;
        logic bad_dllp;
        logic replay_roll;
        logic replay_tmo;
        logic adv_nf;
    } aer_cor_ev_t;

    // Header bytes in arrival order, byte 0 first
    typedef logic [15:0][7:0] aer_hdr_t;

endpackage

// ---- hdl/aer_regs.sv ----
// Purpose: Error severity, correctable status/mask and capability regs
// Assumes: One clock, synchronous active-high reset, AXI4-Lite slave
// Notes:   Header log loads on a logged error
//
// Functional notes
// RQ1 - One read-write severity bit per uncorrectable event: 0 non-fatal, 1 fatal.
// RQ2 - Receiver error sets status bit 0; write-one clears; resets to 0.
// RQ3 - Bad TLP sets status bit 6; write-one clears; resets to 0.
// RQ4 - Bad DLLP sets status bit 7; write-one clears; resets to 0.
// RQ5 - Replay number rollover sets status bit 8; write-one clears; resets 0.
// RQ6 - Replay timer timeout sets status bit 12; write-one clears; resets 0.
// RQ7 - Advisory non-fatal error sets status bit 13; write-one clears; resets 0.
// RQ8 - Mask bit 0 blocks header log and message for receiver error.
// RQ9 - Mask bit 6 blocks header log and message for bad TLP.
// RQ10 - Mask bit 7 blocks header log and message for bad DLLP.
// RQ11 - Mask bit 8 blocks header log and message for replay rollover.
// RQ12 - Mask bit 12 blocks header log and message for replay timeout.
// RQ13 - Mask bit 13 blocks advisory non-fatal log and message; resets to 1.
// RQ14 - Read-only bits 4:0 give first uncorrectable error position; reset zero.
// RQ15 - Read-only bit 5 reads 1: end-to-end CRC generation capable.
// RQ16 - Bit 6 enables end-to-end CRC generation; resets to 0.
// RQ17 - Read-only bit 7 reads 1: end-to-end CRC check capable.
// RQ18 - Bit 8 enables end-to-end CRC checking; resets to 0.
// RQ19 - Capture four header doublewords, bytes big-endian, into read-only log.
// RQ20 - Reserved bits read zero and ignore writes.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps

module aer_regs (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  rst_i,
    // Register bus
    input  wire aer_pkg::aer_axi_req_t axi_req_i,
    output aer_pkg::aer_axi_rsp_t      axi_rsp_o,
    // Error sources
    input  wire aer_pkg::aer_cor_ev_t  cor_ev_i,
    input  wire logic                  ue_log_i,
    input  wire logic [4:0]            ue_pos_i,
    input  wire logic                  hdr_vld_i,
    input  wire aer_pkg::aer_hdr_t     hdr_i,
    // Port controls
    output logic [31:0]                sev_o,
    output logic                       cor_msg_o,
    output logic                       ecrc_gen_en_o,
    output logic                       ecrc_chk_en_o
);
    import aer_pkg::*;

    logic [31:0]      sev_r;
    logic [31:0]      csts_r;
    logic [31:0]      cmsk_r;
    logic [4:0]       fep_r;
    logic             gen_en_r;
    logic             chk_en_r;
    logic [3:0][31:0] hlog_r;
    logic             cor_msg_r;
    logic             awready_r;
    logic             bvalid_r;
    logic [1:0]       bresp_r;
    logic             arready_r;
    logic             rvalid_r;
    logic [31:0]      rdata_r;
    logic [1:0]       rresp_r;
    logic [11:0]      rd_addr_r;

    logic [31:0]      ev;
    logic [31:0]      unmasked;
    logic             log_hdr;
    logic             wr_take;
    logic             rd_take;
    logic [31:0]      wr_val;
    logic [31:0]      rd_val;
    logic             rd_hit;
    logic             wr_hit;

    ////////////////////////////////////////////////////////////////////
    // Event vector and masking

    always_comb begin
        ev                  = 32'h00000000;
        ev[COR_RX_ERR]      = cor_ev_i.rx_err;      // RQ2
        ev[COR_BAD_TLP]     = cor_ev_i.bad_tlp;     // RQ3
        ev[COR_BAD_DLLP]    = cor_ev_i.bad_dllp;    // RQ4
        ev[COR_REPLAY_ROLL] = cor_ev_i.replay_roll; // RQ5
        ev[COR_REPLAY_TMO]  = cor_ev_i.replay_tmo;  // RQ6
        ev[COR_ADV_NF]      = cor_ev_i.adv_nf;      // RQ7
    end

    // Masked events still set status, only log and message stop
    assign unmasked = ev & ~cmsk_r & COR_BITS;  // RQ8 RQ9 RQ10 RQ11 RQ12 RQ13
    assign log_hdr  = ue_log_i | (hdr_vld_i & (|unmasked));

    ////////////////////////////////////////////////////////////////////
    // Bus handshake

    // Address and data are taken together in one cycle
    assign wr_take = axi_req_i.awvalid & axi_req_i.wvalid & awready_r;
    assign rd_take = axi_req_i.arvalid & arready_r;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    assign wr_val = merge(32'h00000000, axi_req_i.wdata, axi_req_i.wstrb);

    always_comb begin
        wr_hit = 1'b0;
        case (axi_req_i.awaddr)
            OFS_SEV, OFS_CSTS, OFS_CMSK, OFS_CAP,
            OFS_HDR0, OFS_HDR1, OFS_HDR2, OFS_HDR3: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            awready_r <= 1'b0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            awready_r <= axi_req_i.awvalid & axi_req_i.wvalid &
                         ~awready_r & ~bvalid_r;
            if (wr_take) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wr_hit ? RESP_OKAY : RESP_SLV;
            end else if (axi_req_i.bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Severity

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sev_r <= SEV_RST;
        end else if (wr_take && axi_req_i.awaddr == OFS_SEV) begin
            sev_r <= merge(sev_r, axi_req_i.wdata, axi_req_i.wstrb)
                     & SEV_BITS;  // RQ1 RQ20
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Correctable status and mask

    // New event wins over a clear in the same cycle
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            csts_r <= CSTS_RST;
        end else if (wr_take && axi_req_i.awaddr == OFS_CSTS) begin
            csts_r <= ((csts_r & ~wr_val) | ev) & COR_BITS;  // RQ2 RQ7
        end else begin
            csts_r <= (csts_r | ev) & COR_BITS;  // RQ3 RQ4 RQ5 RQ6
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmsk_r <= CMSK_RST;  // RQ13
        end else if (wr_take && axi_req_i.awaddr == OFS_CMSK) begin
            cmsk_r <= merge(cmsk_r, axi_req_i.wdata, axi_req_i.wstrb)
                      & COR_BITS;  // RQ20
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cor_msg_r <= 1'b0;
        end else begin
            cor_msg_r <= |unmasked;  // RQ8 RQ13
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Capability, control and first error pointer

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gen_en_r <= 1'b0;
            chk_en_r <= 1'b0;
        end else if (wr_take && axi_req_i.awaddr == OFS_CAP) begin
            if (axi_req_i.wstrb[0]) begin
                gen_en_r <= axi_req_i.wdata[CAP_GEN_EN];  // RQ16
            end
            if (axi_req_i.wstrb[1]) begin
                chk_en_r <= axi_req_i.wdata[CAP_CHK_EN];  // RQ18
            end
        end
    end

    // Pointer is read-only; writes never reach it
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fep_r <= FEP_RST;
        end else if (ue_log_i) begin
            fep_r <= ue_pos_i;  // RQ14
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Header log

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            hlog_r <= '0;
        end else if (log_hdr) begin
            for (int d = 0; d < 4; d++) begin
                hlog_r[d] <= {hdr_i[d*4], hdr_i[d*4+1],
                              hdr_i[d*4+2], hdr_i[d*4+3]};  // RQ19
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read path

    always_comb begin
        rd_val = 32'h00000000;
        rd_hit = 1'b1;
        case (axi_req_i.araddr)
            OFS_SEV: begin
                rd_val = sev_r;
            end
            OFS_CSTS: begin
                rd_val = csts_r;
            end
            OFS_CMSK: begin
                rd_val = cmsk_r;
            end
            OFS_CAP: begin
                rd_val[CAP_FEP_LSB +: 5] = fep_r;  // RQ14
                rd_val[CAP_GEN_CAP]      = 1'b1;   // RQ15
                rd_val[CAP_GEN_EN]       = gen_en_r;
                rd_val[CAP_CHK_CAP]      = 1'b1;   // RQ17
                rd_val[CAP_CHK_EN]       = chk_en_r;
            end
            OFS_HDR0: begin
                rd_val = hlog_r[0];
            end
            OFS_HDR1: begin
                rd_val = hlog_r[1];
            end
            OFS_HDR2: begin
                rd_val = hlog_r[2];
            end
            OFS_HDR3: begin
                rd_val = hlog_r[3];
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= RESP_OKAY;
            rd_addr_r <= 12'h000;
        end else begin
            arready_r <= axi_req_i.arvalid & ~arready_r & ~rvalid_r;
            if (rd_take) begin
                rvalid_r  <= 1'b1;
                rdata_r   <= rd_val;
                rresp_r   <= rd_hit ? RESP_OKAY : RESP_SLV;
                rd_addr_r <= axi_req_i.araddr;
            end else if (axi_req_i.rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        axi_rsp_o.awready = awready_r;
        axi_rsp_o.wready  = awready_r;
        axi_rsp_o.bvalid  = bvalid_r;
        axi_rsp_o.bresp   = bresp_r;
        axi_rsp_o.arready = arready_r;
        axi_rsp_o.rvalid  = rvalid_r;
        axi_rsp_o.rdata   = rdata_r;
        axi_rsp_o.rresp   = rresp_r;
    end

    assign sev_o         = sev_r;
    assign cor_msg_o     = cor_msg_r;
    assign ecrc_gen_en_o = gen_en_r;
    assign ecrc_chk_en_o = chk_en_r;

    ////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_sev_hold;
        !(wr_take && axi_req_i.awaddr == OFS_SEV) |=> $stable(sev_o);
    endproperty
    a_sev_hold: assert property (p_sev_hold) else $error("severity changed"); // RQ1

    property p_rx_set;
        cor_ev_i.rx_err |=> csts_r[COR_RX_ERR] [*1];
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("rx error lost"); // RQ2

    property p_tlp_set;
        cor_ev_i.bad_tlp |=> csts_r[COR_BAD_TLP];
    endproperty
    a_tlp_set: assert property (p_tlp_set) else $error("bad tlp lost"); // RQ3

    property p_tmo_clr;
        wr_take && axi_req_i.awaddr == OFS_CSTS && axi_req_i.wstrb[1] &&
        axi_req_i.wdata[COR_REPLAY_TMO] && !cor_ev_i.replay_tmo
        |=> !csts_r[COR_REPLAY_TMO];
    endproperty
    a_tmo_clr: assert property (p_tmo_clr) else $error("timeout not cleared"); // RQ6

    property p_msg;
        (|(ev & ~cmsk_r & COR_BITS)) |=> cor_msg_o;
    endproperty
    a_msg: assert property (p_msg) else $error("message missing"); // RQ8

    property p_no_msg;
        !(|(ev & ~cmsk_r & COR_BITS)) |=> !cor_msg_o;
    endproperty
    a_no_msg: assert property (p_no_msg) else $error("masked message sent"); // RQ13

    property p_fep;
        ue_log_i |=> fep_r == $past(ue_pos_i);
    endproperty
    a_fep: assert property (p_fep) else $error("first pointer wrong"); // RQ14

    property p_cap_rd;
        rvalid_r && rd_addr_r == OFS_CAP
        |-> rdata_r[CAP_GEN_CAP] && rdata_r[CAP_CHK_CAP] && rdata_r[31:9] == 23'h0;
    endproperty
    a_cap_rd: assert property (p_cap_rd) else $error("capability bits wrong"); // RQ15

    property p_gen_wr;
        wr_take && axi_req_i.awaddr == OFS_CAP && axi_req_i.wstrb[0]
        |=> ecrc_gen_en_o == $past(axi_req_i.wdata[CAP_GEN_EN]) ##1
            $stable(ecrc_gen_en_o) || $past(wr_take);
    endproperty
    a_gen_wr: assert property (p_gen_wr) else $error("crc gen enable wrong"); // RQ16

    property p_hdr;
        log_hdr |=> hlog_r[0] == {$past(hdr_i[0]), $past(hdr_i[1]),
                                  $past(hdr_i[2]), $past(hdr_i[3])};
    endproperty
    a_hdr: assert property (p_hdr) else $error("header order wrong"); // RQ19

    property p_rsvd;
        (csts_r & ~COR_BITS) == 32'h0 && (sev_r & ~SEV_BITS) == 32'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set"); // RQ20

    c_wr:  cover property (wr_take ##[1:4] bvalid_r && axi_req_i.bready);
    c_rd:  cover property (rd_take ##1 rvalid_r && axi_req_i.rready);
    c_set_clr: cover property (wr_take && axi_req_i.awaddr == OFS_CSTS && |ev);
    c_masked:  cover property (|(ev & cmsk_r));

endmodule

// ---- bench/aer_src_model.sv ----
// Purpose: Event source standing in for the port link and transaction layers
// Assumes: The bench calls fire from its main sequence, one event set per call
// Notes:   Header lines are scrambled outside the valid cycle
`timescale 1ns/10ps

module aer_src_model (
    // Clock
    input  wire logic            ref_clk_i,
    // Event outputs
    output aer_pkg::aer_cor_ev_t cor_ev_o,
    output logic                 ue_log_o,
    output logic [4:0]           ue_pos_o,
    output logic                 hdr_vld_o,
    output aer_pkg::aer_hdr_t    hdr_o
);
    import aer_pkg::*;

    initial begin
        cor_ev_o  = '0;
        ue_log_o  = 1'b0;
        ue_pos_o  = 5'h00;
        hdr_vld_o = 1'b0;
        hdr_o     = '0;
    end

    // One-cycle pulse, header valid in the same cycle
    task automatic fire(input logic [5:0] ev, input logic ue, input logic [4:0] pos,
                        input aer_hdr_t h);
        @(posedge ref_clk_i);
        cor_ev_o  <= ev;
        ue_log_o  <= ue;
        ue_pos_o  <= pos;
        hdr_vld_o <= 1'b1;
        hdr_o     <= h;
        @(posedge ref_clk_i);
        cor_ev_o  <= '0;
        ue_log_o  <= 1'b0;
        ue_pos_o  <= ~pos;
        hdr_vld_o <= 1'b0;
        // Stale header must never read back as a good capture
        hdr_o     <= ~h;
    endtask
endmodule

// ---- bench/advanced_error_report_regs_tb.sv ----
// Purpose: Self-checking bench for the error report registers
// Assumes: One register access at a time, responses in issue order
// Notes:   Read and write answers are matched against queued expectations
`timescale 1ns/10ps

module advanced_error_report_regs_tb;
    import aer_pkg::*;

    logic         ref_clk_i = 1'b0;
    logic         rst_i     = 1'b1;
    aer_axi_req_t rq        = '0;
    aer_axi_rsp_t rs;
    aer_cor_ev_t  ev;
    logic         ue;
    logic [4:0]   upos;
    logic         hv;
    aer_hdr_t     hd;
    aer_hdr_t     h0;
    logic [31:0]  sev;
    logic         msg;
    logic         gen;
    logic         cen;
    logic [31:0]  r;
    logic [4:0]   p;
    logic [33:0]  re;
    logic [1:0]   we;
    logic [33:0]  rd_q[$];
    logic [1:0]   wr_q[$];
    int           pos[6]    = '{0, 6, 7, 8, 12, 13};
    int           error_cnt = 0;
    int           tests_run = 0;
    int           cyc       = 0;

    always #50 ref_clk_i = ~ref_clk_i;

    aer_regs aer_regs_inst (
        .ref_clk_i     (ref_clk_i),
        .rst_i         (rst_i),
        .axi_req_i     (rq),
        .axi_rsp_o     (rs),
        .cor_ev_i      (ev),
        .ue_log_i      (ue),
        .ue_pos_i      (upos),
        .hdr_vld_i     (hv),
        .hdr_i         (hd),
        .sev_o         (sev),
        .cor_msg_o     (msg),
        .ecrc_gen_en_o (gen),
        .ecrc_chk_en_o (cen)
    );

    aer_src_model aer_src_model_inst (
        .ref_clk_i (ref_clk_i),
        .cor_ev_o  (ev),
        .ue_log_o  (ue),
        .ue_pos_o  (upos),
        .hdr_vld_o (hv),
        .hdr_o     (hd)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic finish_test();
        $display("Counts: %0d compares, %0d mismatches", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tend(input string s);
        $display("Test %0s done", s);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] e);
        wr_q.push_back(e);
        @(posedge ref_clk_i);
        rq.awvalid <= 1'b1;
        rq.wvalid  <= 1'b1;
        rq.awaddr  <= a;
        rq.wdata   <= d;
        rq.wstrb   <= s;
        rq.bready  <= 1'b1;
        do @(posedge ref_clk_i); while (rs.awready !== 1'b1);
        rq.awvalid <= 1'b0;
        rq.wvalid  <= 1'b0;
        do @(posedge ref_clk_i); while (rs.bvalid !== 1'b1);
        rq.bready  <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] s);
        rd_q.push_back({e, s});
        @(posedge ref_clk_i);
        rq.arvalid <= 1'b1;
        rq.araddr  <= a;
        rq.rready  <= 1'b1;
        do @(posedge ref_clk_i); while (rs.arready !== 1'b1);
        rq.arvalid <= 1'b0;
        do @(posedge ref_clk_i); while (rs.rvalid !== 1'b1);
        rq.rready  <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watches answers and hangs
    always @(posedge ref_clk_i) begin
        cyc++;
        if (rs.rvalid === 1'b1 && rq.rready === 1'b1) begin
            re = rd_q.pop_front();
            chk(rs.rdata, re[33:2]);
            chk({30'h0, rs.rresp}, {30'h0, re[1:0]});
        end
        if (rs.bvalid === 1'b1 && rq.bready === 1'b1) begin
            we = wr_q.pop_front();
            chk({30'h0, rs.bresp}, {30'h0, we});
        end
        // Hang guard last, so nothing runs after the verdict
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(32'hC9BE08E6));
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(OFS_SEV, SEV_RST, RESP_OKAY);
        chk(sev, SEV_RST);
        rd(OFS_CSTS, 32'h0, RESP_OKAY);
        rd(OFS_CMSK, 32'h00002000, RESP_OKAY);
        rd(OFS_CAP, 32'h000000A0, RESP_OKAY);
        rd(OFS_HDR0, 32'h0, RESP_OKAY);
        rd(12'h100, 32'h0, RESP_SLV);
        wr(12'h200, 32'hFFFFFFFF, 4'hF, RESP_SLV);
        tend("reset");

        r = $urandom();
        for (int k = 0; k < 2; k++) begin
            wr(OFS_SEV, r, 4'hF, RESP_OKAY);
            rd(OFS_SEV, r & 32'h003FF011, RESP_OKAY);
            chk(sev, r & 32'h003FF011);
            r = ~r;
        end
        wr(OFS_CMSK, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(OFS_CMSK, 32'h000031C1, RESP_OKAY);
        wr(OFS_CSTS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(OFS_CSTS, 32'h0, RESP_OKAY);
        tend("severity");

        for (int i = 0; i < 6; i++) begin
            wr(OFS_CMSK, 32'h0, 4'hF, RESP_OKAY);
            for (int b = 0; b < 16; b++) h0[b] = 8'($urandom());
            aer_src_model_inst.fire(6'h20 >> i, 1'b0, 5'h00, h0);
            #1;
            chk({31'h0, msg}, 32'h1);
            rd(OFS_CSTS, 32'h1 << pos[i], RESP_OKAY);
            for (int d = 0; d < 4; d++) begin
                rd(OFS_HDR0 + 12'(4 * d), {h0[4*d], h0[4*d+1], h0[4*d+2], h0[4*d+3]},
                   RESP_OKAY);
            end
            // Strobe off the flag's byte: nothing may clear
            wr(OFS_CSTS, 32'h1 << pos[i], ~(4'h1 << (pos[i] / 8)), RESP_OKAY);
            rd(OFS_CSTS, 32'h1 << pos[i], RESP_OKAY);
            wr(OFS_CSTS, 32'h1 << pos[i], 4'hF, RESP_OKAY);
            rd(OFS_CSTS, 32'h0, RESP_OKAY);
            wr(OFS_CMSK, 32'h1 << pos[i], 4'hF, RESP_OKAY);
            aer_src_model_inst.fire(6'h20 >> i, 1'b0, 5'h00, ~h0);
            #1;
            chk({31'h0, msg}, 32'h0);
            rd(OFS_HDR0, {h0[0], h0[1], h0[2], h0[3]}, RESP_OKAY);
            rd(OFS_CSTS, 32'h1 << pos[i], RESP_OKAY);
            wr(OFS_CSTS, 32'h1 << pos[i], 4'hF, RESP_OKAY);
        end
        wr(OFS_CMSK, 32'h0, 4'hF, RESP_OKAY);
        // Event and clear land on one edge: the event must survive
        fork
            wr(OFS_CSTS, 32'h1, 4'hF, RESP_OKAY);
            begin
                @(posedge ref_clk_i);
                aer_src_model_inst.fire(6'h20, 1'b0, 5'h00, h0);
            end
        join
        rd(OFS_CSTS, 32'h1, RESP_OKAY);
        aer_src_model_inst.fire(6'h3F, 1'b0, 5'h00, h0);
        rd(OFS_CSTS, 32'h000031C1, RESP_OKAY);
        tend("events");

        wr(OFS_CAP, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
        rd(OFS_CAP, 32'h000001E0, RESP_OKAY);
        chk({30'h0, gen, cen}, 32'h3);
        wr(OFS_CAP, 32'h0, 4'h1, RESP_OKAY);
        rd(OFS_CAP, 32'h000001A0, RESP_OKAY);
        chk({30'h0, gen, cen}, 32'h1);
        p = 5'($urandom());
        for (int b = 0; b < 16; b++) h0[b] = 8'($urandom());
        aer_src_model_inst.fire(6'h00, 1'b1, p, h0);
        rd(OFS_CAP, 32'h000001A0 | {27'h0, p}, RESP_OKAY);
        rd(OFS_HDR3, {h0[12], h0[13], h0[14], h0[15]}, RESP_OKAY);
        wr(OFS_HDR3, 32'h0, 4'hF, RESP_OKAY);
        wr(OFS_CAP, 32'h0, 4'hF, RESP_OKAY);
        rd(OFS_CAP, 32'h000000A0 | {27'h0, p}, RESP_OKAY);
        chk({30'h0, gen, cen}, 32'h0);
        rd(OFS_HDR3, {h0[12], h0[13], h0[14], h0[15]}, RESP_OKAY);
        tend("capability");
        finish_test();
    end
endmodule
